// ---- verilog/ext_irq_defines.svh ----
// register offsets, field positions and reset values of the external interrupt flag block
// assumes inclusion by bare name from the top module and the bench
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// axi4-lite byte addresses
`define ADDR_REQ_ONE 8'h00
`define ADDR_REQ_TWO 8'h04
`define ADDR_WAKE_REQ 8'h08
`define ADDR_PFR_B 8'h0c
`define ADDR_PFR_2 8'h10
`define ADDR_PFR_5 8'h14
`define ADDR_EDGE_SEL 8'h18
`define ADDR_ASYNC_EDGE 8'h1c
`define ADDR_IEN_ONE 8'h20
`define ADDR_WAKE_EDGE 8'h24
`define ADDR_INT_STATUS 8'h28
`define ADDR_INT_MASK 8'h2c
`define ADDR_SP 8'h30
`define ADDR_CCR 8'h34
`define ADDR_EXC_CMD 8'h38

// field positions
`define REQ_IRQ0 0
`define REQ_IRQ1 1
`define REQ_ASYNC 2
`define FUNC_SEL_BIT 0
`define EDGE_IRQ0 0
`define EDGE_IRQ1 1
`define IEN_ASYNC 2
`define CCR_IBIT 7
`define CMD_ENTER 0
`define CMD_RETURN 1
`define ST_IRQ0 0
`define ST_IRQ1 1
`define ST_ASYNC 2
`define ST_WAKE 3
`define ST_INTERNAL 4
`define LANE0 0
`define LANE1 1
`define SP_TOP_BIT 8

// async edge select encodings
`define ASYNC_FALL 2'h0
`define ASYNC_RISE 2'h1
`define ASYNC_BOTH 2'h2

// reset values and constants
`define SP_RESET 9'h000
`define CCR_RESET 8'h80
`define WORD_STEP 9'h002
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verilog/ext_irq_pkg.sv ----
// types of the external interrupt flag block
// assumes the defines header sits beside it
package ext_irq_pkg;

    typedef enum logic [1:0] {EXC_IDLE, EXC_POP_LOAD} exc_state_t;

    typedef struct packed {
        logic [1:0] irq_meta;
        logic [1:0] irq_sync;
        logic [1:0] irq_prev;
        logic async_meta;
        logic async_sync;
        logic async_prev;
        logic [7:0] wake_meta;
        logic [7:0] wake_sync;
        logic [7:0] wake_prev;
        logic [2:0] req_one;
        logic [7:0] req_two;
        logic [7:0] wake_req;
        logic irq1_func;
        logic irq0_func;
        logic [7:0] wake_func;
        logic [1:0] irq_edge;
        logic [1:0] async_edge;
        logic [2:0] ien_one;
        logic [7:0] wake_edge;
        logic [4:0] status;
        logic [4:0] mask;
        logic [8:0] sp;
        logic [7:0] condition_code_reg;
        logic after_pfr;
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        exc_state_t exc;
    } ctl_state_t;

endpackage : ext_irq_pkg

// ---- verilog/stack_word_mem.sv ----
// word-wide stack memory with registered read data
// assumes one clock; write and read ports are used one at a time
`timescale 1ns/1ps
`default_nettype none
module stack_word_mem #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
) (
    input wire logic aclk,
    input wire logic we,
    input wire logic re,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        if (re)
        begin
            rdata <= mem[addr];
        end
    end
endmodule : stack_word_mem
`default_nettype wire

// ---- verilog/ext_irq_flag_pin_switch_logic.sv ----
// external interrupt request flags, pin function switching effects, and ccr stacking
// assumes pins are asynchronous, software on an axi4-lite master, one clock aclk
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defines.svh"

// Overview of operation
// R1 - irq1 flag sets when its function bit rises, pin low, edge select 0
// R2 - irq1 flag sets when its function bit falls, pin low, edge select 1
// R3 - irq0 flag sets when its function bit rises, pin low, edge select 0
// R4 - irq0 flag sets when its function bit falls, pin low, edge select 1
// R5 - each wakeup flag sets when its function bit rises while its pin is low
// R6 - async event flag sets on the selected edge while its enable is 1
// R7 - a flag clear right after a port function access is ignored
// R8 - software masks, switches, waits one instruction, then clears spurious flags
// R9 - software may hold the pins high while switching their function
// R10 - byte write clears flags written 0, keeps flags written 1
// R11 - the irq1 flag is bit 1 of the first request register
// R12 - software clears flags with one instruction, not read-modify-write
// R13 - word accesses force address bit 0 to zero
// R14 - entry pushes ccr as a word; return loads ccr from the even byte
// R15 - software keeps the stack pointer even
// R16 - a set wakeup flag clears when software writes 0 to it
// R17 - wakeup edge select 0 picks falling edge, 1 picks rising edge
// R18 - spurious flags set in the write cycle from the synchronised pin level
// R19 - a set flag stays set until cleared by software or reset
module ext_irq_flag_pin_switch_logic (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq0_pin,
    input wire logic irq1_pin,
    input wire logic async_event_pin,
    input wire logic [7:0] wakeup_pin,
    input wire logic [7:0] internal_event,
    output logic irq
);
    ext_irq_pkg::ctl_state_t s;
    ext_irq_pkg::ctl_state_t n;
    logic do_write;
    logic do_read;
    logic mem_we;
    logic mem_re;
    logic [7:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [8:0] sp_aligned;
    logic [7:0] ret_ccr_byte;

    function automatic logic switch_set(input logic old_sel, input logic new_sel, input logic pin,
                                        input logic edge_sel);
        switch_set = !pin && ((!old_sel && new_sel && !edge_sel) || (old_sel && !new_sel && edge_sel));
    endfunction : switch_set

    function automatic logic edge_hit(input logic prev, input logic now, input logic rising);
        edge_hit = rising ? (!prev && now) : (prev && !now);
    endfunction : edge_hit

    function automatic logic [8:0] word_align(input logic [8:0] addr);
        word_align = {addr[8:1], 1'h0};
    endfunction : word_align

    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            `ADDR_REQ_ONE, `ADDR_REQ_TWO, `ADDR_WAKE_REQ, `ADDR_PFR_B, `ADDR_PFR_2, `ADDR_PFR_5,
            `ADDR_EDGE_SEL, `ADDR_ASYNC_EDGE, `ADDR_IEN_ONE, `ADDR_WAKE_EDGE, `ADDR_INT_STATUS,
            `ADDR_INT_MASK, `ADDR_SP, `ADDR_CCR, `ADDR_EXC_CMD: addr_known = 1'h1;
            default: addr_known = 1'h0;
        endcase
    endfunction : addr_known

    assign s_axi_awready = !s.aw_held;
    assign s_axi_wready = !s.w_held;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign irq = |(s.status & s.mask);
    assign do_write = s.aw_held && s.w_held && !s.bvalid;
    assign do_read = s_axi_arvalid && !s.rvalid;
    assign sp_aligned = word_align(s.sp);
    assign ret_ccr_byte = mem_rdata[15:8];

    stack_word_mem #(
        .ADDR_W(8),
        .DATA_W(16)
    ) u_stack (
        .aclk(aclk),
        .we(mem_we),
        .re(mem_re),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    always_comb
    begin
        logic [7:0] wb;
        logic [2:0] set_one;
        logic [7:0] set_wake;
        logic [4:0] ev;
        logic [7:0] rd;
        logic clr_ok;
        wb = s.wdata[7:0];
        set_one = 3'h0;
        set_wake = 8'h00;
        ev = 5'h00;
        rd = 8'h00;
        clr_ok = do_write && s.wstrb[`LANE0] && !s.after_pfr;
        n = s;
        mem_we = 1'h0;
        mem_re = 1'h0;
        mem_addr = sp_aligned[8:1];
        mem_wdata = {s.condition_code_reg, s.condition_code_reg};
        // pin synchronisers and edge history
        n.irq_meta = {irq1_pin, irq0_pin};
        n.irq_sync = s.irq_meta;
        n.irq_prev = s.irq_sync;
        n.async_meta = async_event_pin;
        n.async_sync = s.async_meta;
        n.async_prev = s.async_sync;
        n.wake_meta = wakeup_pin;
        n.wake_sync = s.wake_meta;
        n.wake_prev = s.wake_sync;
        // axi write channel capture
        if (s_axi_awvalid && !s.aw_held)
        begin
            n.aw_held = 1'h1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_held)
        begin
            n.w_held = 1'h1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'h0;
        end
        if (s.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'h0;
        end
        // clears: flags written 0 drop, flags written 1 stay
        if (clr_ok && s.awaddr == `ADDR_REQ_ONE)
        begin
            n.req_one = s.req_one & wb[2:0]; // see R10 see R11 see R7
        end
        if (clr_ok && s.awaddr == `ADDR_REQ_TWO)
        begin
            n.req_two = s.req_two & wb; // see R10 see R7
        end
        if (clr_ok && s.awaddr == `ADDR_WAKE_REQ)
        begin
            n.wake_req = s.wake_req & wb; // see R16 see R7
        end
        if (do_write)
        begin
            n.aw_held = 1'h0;
            n.w_held = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = addr_known(s.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
            n.after_pfr = (s.awaddr == `ADDR_PFR_B) || (s.awaddr == `ADDR_PFR_2)
                || (s.awaddr == `ADDR_PFR_5); // see R7
            if (s.wstrb[`LANE0])
            begin
                case (s.awaddr)
                    `ADDR_PFR_B:
                    begin
                        n.irq1_func = wb[`FUNC_SEL_BIT];
                        set_one[`REQ_IRQ1] = switch_set(s.irq1_func, wb[`FUNC_SEL_BIT], s.irq_sync[1],
                            s.irq_edge[`EDGE_IRQ1]); // see R1 see R2 see R18
                    end
                    `ADDR_PFR_2:
                    begin
                        n.irq0_func = wb[`FUNC_SEL_BIT];
                        set_one[`REQ_IRQ0] = switch_set(s.irq0_func, wb[`FUNC_SEL_BIT], s.irq_sync[0],
                            s.irq_edge[`EDGE_IRQ0]); // see R3 see R4 see R18
                    end
                    `ADDR_PFR_5:
                    begin
                        n.wake_func = wb;
                        set_wake = ~s.wake_func & wb & ~s.wake_sync; // see R5 see R18
                    end
                    `ADDR_EDGE_SEL: n.irq_edge = wb[1:0];
                    `ADDR_ASYNC_EDGE: n.async_edge = wb[1:0];
                    `ADDR_IEN_ONE: n.ien_one = wb[2:0];
                    `ADDR_WAKE_EDGE: n.wake_edge = wb;
                    `ADDR_INT_STATUS: n.status = s.status & ~wb[4:0];
                    `ADDR_INT_MASK: n.mask = wb[4:0];
                    `ADDR_SP: n.sp[7:0] = wb;
                    `ADDR_CCR: n.condition_code_reg = wb;
                    default:
                    begin
                    end
                endcase
            end
            if (s.wstrb[`LANE1] && s.awaddr == `ADDR_SP)
            begin
                n.sp[`SP_TOP_BIT] = s.wdata[`SP_TOP_BIT];
            end
        end
        else if (do_read)
        begin
            n.after_pfr = 1'h0; // see R7
        end
        // axi read
        case (s_axi_araddr)
            `ADDR_REQ_ONE: rd = {5'h00, s.req_one};
            `ADDR_REQ_TWO: rd = s.req_two;
            `ADDR_WAKE_REQ: rd = s.wake_req;
            `ADDR_PFR_B: rd = {7'h00, s.irq1_func};
            `ADDR_PFR_2: rd = {7'h00, s.irq0_func};
            `ADDR_PFR_5: rd = s.wake_func;
            `ADDR_EDGE_SEL: rd = {6'h00, s.irq_edge};
            `ADDR_ASYNC_EDGE: rd = {6'h00, s.async_edge};
            `ADDR_IEN_ONE: rd = {5'h00, s.ien_one};
            `ADDR_WAKE_EDGE: rd = s.wake_edge;
            `ADDR_INT_STATUS: rd = {3'h0, s.status};
            `ADDR_INT_MASK: rd = {3'h0, s.mask};
            `ADDR_SP: rd = s.sp[7:0];
            `ADDR_CCR: rd = s.condition_code_reg;
            default: rd = 8'h00;
        endcase
        if (do_read)
        begin
            n.rvalid = 1'h1;
            n.rresp = addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            n.rdata = (s_axi_araddr == `ADDR_SP) ? {23'h0, s.sp} : {24'h0, rd};
        end
        // real pin edges while the pin function is selected, or for the async pin while its enable is 1
        if (s.irq0_func && edge_hit(s.irq_prev[0], s.irq_sync[0], s.irq_edge[`EDGE_IRQ0]))
        begin
            set_one[`REQ_IRQ0] = 1'h1;
        end
        if (s.irq1_func && edge_hit(s.irq_prev[1], s.irq_sync[1], s.irq_edge[`EDGE_IRQ1]))
        begin
            set_one[`REQ_IRQ1] = 1'h1;
        end
        if (s.ien_one[`IEN_ASYNC])
        begin
            case (s.async_edge)
                `ASYNC_FALL: set_one[`REQ_ASYNC] = edge_hit(s.async_prev, s.async_sync, 1'h0); // see R6
                `ASYNC_RISE: set_one[`REQ_ASYNC] = edge_hit(s.async_prev, s.async_sync, 1'h1); // see R6
                `ASYNC_BOTH: set_one[`REQ_ASYNC] = s.async_prev ^ s.async_sync; // see R6
                default: set_one[`REQ_ASYNC] = 1'h0;
            endcase
        end
        for (int i = 0; i < 8; i++)
        begin
            if (s.wake_func[i] && edge_hit(s.wake_prev[i], s.wake_sync[i], s.wake_edge[i])) // see R17
            begin
                set_wake[i] = 1'h1;
            end
        end
        // sets win over clears; flags hold otherwise
        n.req_one = n.req_one | set_one; // see R19
        n.wake_req = n.wake_req | set_wake; // see R19
        n.req_two = n.req_two | internal_event; // see R19
        ev[`ST_IRQ0] = set_one[`REQ_IRQ0] && !s.req_one[`REQ_IRQ0];
        ev[`ST_IRQ1] = set_one[`REQ_IRQ1] && !s.req_one[`REQ_IRQ1];
        ev[`ST_ASYNC] = set_one[`REQ_ASYNC] && !s.req_one[`REQ_ASYNC];
        ev[`ST_WAKE] = |(set_wake & ~s.wake_req);
        ev[`ST_INTERNAL] = |(internal_event & ~s.req_two);
        n.status = n.status | ev;
        // exception entry and return stacking
        case (s.exc)
            ext_irq_pkg::EXC_IDLE:
            begin
                if (do_write && s.wstrb[`LANE0] && s.awaddr == `ADDR_EXC_CMD)
                begin
                    if (wb[`CMD_ENTER])
                    begin
                        n.sp = sp_aligned - `WORD_STEP; // see R13
                        mem_addr = n.sp[8:1]; // see R13
                        mem_we = 1'h1; // see R14
                        n.condition_code_reg[`CCR_IBIT] = 1'h1;
                    end
                    else if (wb[`CMD_RETURN])
                    begin
                        mem_re = 1'h1; // see R13
                        n.exc = ext_irq_pkg::EXC_POP_LOAD;
                    end
                end
            end
            ext_irq_pkg::EXC_POP_LOAD:
            begin
                n.condition_code_reg = mem_rdata[15:8]; // see R14
                n.sp = sp_aligned + `WORD_STEP; // see R13
                n.exc = ext_irq_pkg::EXC_IDLE;
            end
            default: n.exc = ext_irq_pkg::EXC_IDLE;
        endcase
        if (!aresetn)
        begin
            n = '0;
            n.sp = `SP_RESET;
            n.condition_code_reg = `CCR_RESET;
            n.exc = ext_irq_pkg::EXC_IDLE;
            mem_we = 1'h0;
            mem_re = 1'h0;
        end
    end

    always_ff @(posedge aclk)
    begin
        s <= n;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_ret_start;
        s.exc == ext_irq_pkg::EXC_IDLE && do_write && s.wstrb[`LANE0] && s.awaddr == `ADDR_EXC_CMD
            && !s.wdata[`CMD_ENTER] && s.wdata[`CMD_RETURN];
    endsequence
    sequence seq_ret_load;
        s.exc == ext_irq_pkg::EXC_POP_LOAD;
    endsequence

    AST_R1_SWITCH_RISE: assert property (do_write && s.wstrb[`LANE0] && s.awaddr == `ADDR_PFR_B // see R1
        && !s.irq1_func && s.wdata[`FUNC_SEL_BIT] && !s.irq_sync[1] && !s.irq_edge[`EDGE_IRQ1]
        |=> s.req_one[`REQ_IRQ1] && (s.status[`ST_IRQ1] || $past(s.req_one[`REQ_IRQ1])))
        else $error("irq1 flag missed on select rise");
    AST_R2_SWITCH_FALL: assert property (do_write && s.wstrb[`LANE0] && s.awaddr == `ADDR_PFR_B // see R2
        && s.irq1_func && !s.wdata[`FUNC_SEL_BIT] && !s.irq_sync[1] && s.irq_edge[`EDGE_IRQ1]
        |=> s.req_one[`REQ_IRQ1]) else $error("irq1 flag missed on select fall");
    AST_R3_SWITCH_RISE: assert property (do_write && s.wstrb[`LANE0] && s.awaddr == `ADDR_PFR_2 // see R3
        && !s.irq0_func && s.wdata[`FUNC_SEL_BIT] && !s.irq_sync[0] && !s.irq_edge[`EDGE_IRQ0]
        |=> s.req_one[`REQ_IRQ0]) else $error("irq0 flag missed on select rise");
    AST_R4_SWITCH_FALL: assert property (do_write && s.wstrb[`LANE0] && s.awaddr == `ADDR_PFR_2 // see R4
        && s.irq0_func && !s.wdata[`FUNC_SEL_BIT] && !s.irq_sync[0] && s.irq_edge[`EDGE_IRQ0]
        |=> s.req_one[`REQ_IRQ0]) else $error("irq0 flag missed on select fall");
    AST_R5_WAKE_SWITCH: assert property (do_write && s.wstrb[`LANE0] && s.awaddr == `ADDR_PFR_5 // see R5
        && !s.wake_func[0] && s.wdata[0] && !s.wake_sync[0] |=> s.wake_req[0])
        else $error("wakeup0 flag missed on select rise");
    AST_R6_ASYNC_EDGE: assert property (s.ien_one[`IEN_ASYNC] && s.async_edge == `ASYNC_RISE // see R6
        && $rose(s.async_sync) |=> s.req_one[`REQ_ASYNC]) else $error("async flag missed on rising edge");
    AST_R7_CLEAR_LOST: assert property (do_write && s.after_pfr && s.awaddr == `ADDR_REQ_ONE // see R7
        |=> (s.req_one & $past(s.req_one)) == $past(s.req_one)) else $error("clear acted after function access");
    AST_R10_KEEP_ONES: assert property (do_write && !s.after_pfr && s.wstrb[`LANE0] // see R10
        && s.awaddr == `ADDR_REQ_ONE && s.wdata[`REQ_IRQ0] && s.req_one[`REQ_IRQ0] |=> s.req_one[`REQ_IRQ0])
        else $error("flag written one was cleared");
    AST_R16_WAKE_CLEAR: assert property (do_write && !s.after_pfr && s.wstrb[`LANE0] // see R16
        && s.awaddr == `ADDR_WAKE_REQ && !s.wdata[0] && s.wake_prev[0] == s.wake_sync[0] |=> !s.wake_req[0])
        else $error("wakeup0 flag not cleared by zero");
    AST_R13_PUSH_ALIGN: assert property (s.exc == ext_irq_pkg::EXC_IDLE && do_write // see R13
        && s.wstrb[`LANE0] && s.awaddr == `ADDR_EXC_CMD && s.wdata[`CMD_ENTER]
        |=> s.sp == $past(sp_aligned) - `WORD_STEP && s.condition_code_reg[`CCR_IBIT]) else $error("push not word aligned");
    AST_R14_RETURN: assert property (seq_ret_start |=> seq_ret_load ##1 // see R14
        (s.condition_code_reg == $past(ret_ccr_byte) && s.sp[0] == 1'h0)) else $error("return did not load even byte");
    AST_R19_HOLD: assert property (s.req_one[`REQ_IRQ1] && !(do_write && s.awaddr == `ADDR_REQ_ONE) // see R19
        |=> s.req_one[`REQ_IRQ1]) else $error("irq1 flag dropped without clear");
endmodule : ext_irq_flag_pin_switch_logic
`default_nettype wire

// ---- tb/pin_model.sv ----
// model of the external interrupt pins driven by the outside world
// assumes the bench sets target levels; idle level is high (pull-up)
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic aclk,
    input wire logic [10:0] level,
    output logic [10:0] pins
);
    // pins follow the requested level one edge later
    always_ff @(posedge aclk)
    begin
        pins <= level;
    end
endmodule : pin_model
`default_nettype wire

// ---- tb/tb_ext_irq_flag_pin_switch_logic.sv ----
// self-checking bench of the interrupt flag block
// assumes the defines header and the pin model beside the design
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defines.svh"
module tb_ext_irq_flag_pin_switch_logic;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] internal_event = 8'h00;
    logic [10:0] level = 11'h7ff;
    logic [10:0] pins;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    int n_fail = 0;
    int compares = 0;

    pin_model u_pin_model (.aclk(aclk), .level(level), .pins(pins));

    ext_irq_flag_pin_switch_logic u_ext_irq_flag_pin_switch_logic (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(rready), .irq0_pin(pins[0]), .irq1_pin(pins[1]), .async_event_pin(pins[2]),
        .wakeup_pin(pins[10:3]), .internal_event(internal_event), .irq(irq)
    );

    initial
    begin
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ra, rw, rb;
        int t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        rb = 1'b0;
        for (t = 0; t < 64 && !rb; t++)
        begin
            @(negedge aclk);
            ra = s_axi_awready;
            rw = s_axi_wready;
            rb = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (ra) awvalid <= 1'b0;
            if (rw) wvalid <= 1'b0;
            if (rb) bready <= 1'b0;
        end
        chk({31'h0, rb}, 32'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ra, rv;
        int t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rv = 1'b0;
        for (t = 0; t < 64 && !rv; t++)
        begin
            @(negedge aclk);
            ra = s_axi_arready;
            rv = s_axi_rvalid;
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ra) arvalid <= 1'b0;
            if (rv) rready <= 1'b0;
        end
        chk({31'h0, rv}, 32'h1);
    endtask : rd

    task automatic settle;
        repeat (6) @(posedge aclk);
    endtask : settle

    task automatic t_switch_on;
        level <= 11'h000;
        wr(`ADDR_INT_MASK, 32'h0);
        chk({30'h0, resp}, 32'h0);
        settle();
        wr(`ADDR_PFR_B, 32'h1);
        wr(`ADDR_PFR_2, 32'h1);
        rd(`ADDR_REQ_ONE);
        chk(rdat, 32'h3);
        wr(`ADDR_PFR_5, 32'hff);
        wr(`ADDR_WAKE_REQ, 32'h0);
        rd(`ADDR_WAKE_REQ);
        chk(rdat, 32'hff);
        wr(`ADDR_WAKE_REQ, 32'h0);
        rd(`ADDR_WAKE_REQ);
        chk(rdat, 32'h0);
        wr(`ADDR_REQ_ONE, 32'hfd);
        rd(`ADDR_REQ_ONE);
        chk(rdat, 32'h1);
    endtask : t_switch_on

    task automatic t_switch_off;
        wr(`ADDR_REQ_ONE, 32'h0);
        wr(`ADDR_EDGE_SEL, 32'h3);
        rd(`ADDR_REQ_ONE);
        chk(rdat, 32'h0);
        wr(`ADDR_PFR_B, 32'h0);
        wr(`ADDR_PFR_2, 32'h0);
        wr(`ADDR_REQ_ONE, 32'h0);
        rd(`ADDR_REQ_ONE);
        chk(rdat, 32'h3);
    endtask : t_switch_off

    task automatic t_async_wake;
        wr(`ADDR_ASYNC_EDGE, 32'h1);
        wr(`ADDR_IEN_ONE, 32'h4);
        wr(`ADDR_WAKE_EDGE, 32'h0f);
        wr(`ADDR_REQ_ONE, 32'h0);
        level <= 11'h7fc;
        settle();
        rd(`ADDR_REQ_ONE);
        chk(rdat, 32'h4);
        rd(`ADDR_WAKE_REQ);
        chk(rdat, 32'h0f);
    endtask : t_async_wake

    task automatic t_irq;
        wr(`ADDR_INT_MASK, 32'h0);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(`ADDR_INT_MASK, 32'h1f);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`ADDR_INT_STATUS, 32'h1f);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
        @(posedge aclk);
        internal_event <= 8'h01;
        @(posedge aclk);
        internal_event <= 8'h00;
        settle();
        chk({31'h0, irq}, 32'h1);
        rd(`ADDR_REQ_TWO);
        chk(rdat, 32'h1);
        wr(`ADDR_INT_MASK, 32'h0);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    task automatic t_stack;
        wr(`ADDR_CCR, 32'h05);
        wr(`ADDR_SP, 32'h1fd);
        wr(`ADDR_EXC_CMD, 32'h1);
        rd(`ADDR_SP);
        chk(rdat, 32'h1fa);
        rd(`ADDR_CCR);
        chk(rdat, 32'h85);
        wr(`ADDR_CCR, 32'h0);
        wr(`ADDR_EXC_CMD, 32'h2);
        settle();
        rd(`ADDR_CCR);
        chk(rdat, 32'h05);
        rd(`ADDR_SP);
        chk(rdat, 32'h1fc);
    endtask : t_stack

    task automatic t_unmapped;
        wr(8'h3c, 32'hff);
        chk({30'h0, resp}, 32'h2);
        rd(8'h3c);
        chk({30'h0, resp}, 32'h2);
        chk(rdat, 32'h0);
    endtask : t_unmapped

    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_switch_on();
        t_switch_off();
        t_async_wake();
        t_irq();
        t_stack();
        t_unmapped();
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        test_done();
    end
endmodule : tb_ext_irq_flag_pin_switch_logic
`default_nettype wire
